// [src/ttcr_pkg.sv]
// Constants shared by the thermal timer, tachometer and pin configuration register block.
package ttcr_pkg;

    // ========================================================================
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [6:0] IDX_IRQ_STATUS = 7'h42;
    localparam logic [6:0] IDX_CTRL       = 7'h70;
    localparam logic [6:0] IDX_IRQ_MASK   = 7'h71;
    localparam logic [6:0] IDX_TIMER      = 7'h72;
    localparam logic [6:0] IDX_LIMIT      = 7'h7A;
    localparam logic [6:0] IDX_TACH       = 7'h7B;
    localparam logic [6:0] IDX_CFG        = 7'h7C;

    // ========================================================================
    // Reset values.
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [7:0] RST_TACH  = 8'h55;
    localparam logic [7:0] RST_CFG   = 8'h00;
    localparam logic [7:0] RST_ZERO  = 8'h00;

    // ========================================================================
    // Field positions of the pin configuration register.
    localparam int CFG_SIGNED    = 0;
    localparam int CFG_RANGE     = 1;
    localparam int CFG_DIR       = 2;
    localparam int CFG_POL       = 3;
    localparam int CFG_REMOTE_EN = 5;
    localparam int CFG_LOCAL_EN  = 6;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hEF;

    // Control register fields and multi-function pin codes.
    localparam int CTRL_LOCK     = 0;
    localparam int CTRL_FUNC_LSB = 1;
    localparam int CTRL_GP_IN    = 3;
    localparam logic [1:0] FUNC_ALARM = 2'h1;
    localparam logic [1:0] FUNC_GPIO  = 2'h3;

    // Interrupt status bits.
    localparam int IRQ_ASSERT = 0;
    localparam int IRQ_EXCEED = 5;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h21;

    // Alarm limit codes that switch the pin drive of a channel off, and duration count values.
    localparam logic [7:0] LIMIT_OFF_OFS64 = 8'h00;
    localparam logic [7:0] LIMIT_OFF_TWOS  = 8'h80;
    localparam logic [7:0] DUR_ZERO        = 8'h00;
    localparam logic [7:0] DUR_ONE         = 8'h01;
    localparam logic [7:0] DUR_MAX         = 8'hFF;

    // Tachometer field width.
    localparam int TACH_FW = 2;

    // ========================================================================
    // Timing: one duration step in nanoseconds at a 50 ns clock.
    localparam longint STEP_NS     = 64'd22760000;
    localparam longint CLK_NS      = 64'd50;
    localparam int     STEP_CYCLES = int'(STEP_NS / CLK_NS);

    // Duration timer states, Gray coded along idle, timing, saturated.
    typedef enum logic [1:0] {
        TTCR_IDLE   = 2'b00,
        TTCR_TIMING = 2'b01,
        TTCR_SATUR  = 2'b11
    } ttcr_state_e;

endpackage

// [src/ttcr_top.sv]
// Thermal alarm timer, tachometer pulse count and pin configuration registers.
`timescale 1ns/1ns

// What this block does
// - Holds an 8-bit alarm duration limit counted in 22.76 ms steps.
// - Sets the duration exceeded flag, status bit 5, when the limit is passed.
// - A zero limit sets the exceeded flag right when the alarm asserts.
// - Two-bit codes 0..3 select one to four pulses; register resets to 0x55.
// - Fields for fans a to d sit at bits 1:0, 3:2, 5:4, 7:6.
// - Bit 0 selects twos complement (1) or offset-64 (0) temperature format.
// - Bit 1 selects 64 degrees at half steps or 128 degrees at whole steps.
// - Bit 2 makes the general pin an input (0) or output (1).
// - Bit 3 makes the general output active low (0) or high (1).
// - Bit 5 lets a remote channel over-limit drive the alarm pin.
// - Bit 6 lets a local channel over-limit drive the alarm pin.
// - A limit of -64 or -128 code, per format, disables that channel's drive.
// - Once the lock bit is set, the configuration register ignores writes.
// - Times alarm assertion in steps; assertion flag clears when read.
// - Direction and polarity act only when the pin function code is 11.
module ttcr_top #(
    parameter int N_FANS        = 4,
    parameter int STEP_CYCLES   = ttcr_pkg::STEP_CYCLES
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire logic [8:0]            i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic      [31:0]           o_avs_readdata,
    output logic                       o_avs_waitrequest,
    input  wire logic                  i_multi_pin,
    output logic                       o_multi_pin,
    output logic                       o_multi_pin_oe,
    input  wire logic                  i_gp_out_value,
    input  wire logic                  i_remote_a_over_limit,
    input  wire logic [7:0]            i_remote_a_alarm_limit,
    input  wire logic                  i_local_over_limit,
    input  wire logic [7:0]            i_local_alarm_limit,
    output logic                       o_signed_format_select,
    output logic                       o_offset_range_select,
    output logic      [N_FANS*3-1:0]   o_tach_pulses,
    output logic                       o_irq
);

    localparam int TW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
    localparam logic [TW-1:0] TICK_LAST = TW'(STEP_CYCLES - 1);
    localparam logic [TW-1:0] TICK_ZERO = '0;
    localparam logic [TW-1:0] TICK_ONE  = TW'(1);

    // ========================================================================
    // Register storage.
    logic [7:0]  limit_reg;
    logic [7:0]  tach_reg;
    logic [7:0]  cfg_reg;
    logic [7:0]  irq_stat_reg;
    logic [7:0]  irq_stat_next;
    logic [7:0]  irq_mask_reg;
    logic        lock_reg;
    logic [1:0]  func_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;

    // Timer state.
    ttcr_pkg::ttcr_state_e state_reg;
    logic [TW-1:0] tick_cnt_reg;
    logic [7:0]    dur_reg;
    logic          tick;
    logic          alarm_on;
    logic          start;
    logic          exceed_evt;

    // Bus decode.
    logic [6:0]  idx;
    logic        req;
    logic        done;
    logic        wr_done;
    logic        rd_done;
    logic [7:0]  rd_mux;

    // Pin drive.
    logic        remote_off;
    logic        local_off;
    logic        alarm_drive;
    logic        pin_next;
    logic        oe_next;
    logic [7:0]  ctrl_view;

    // ========================================================================
    // Avalon slave: every access waits exactly one cycle, which keeps the read
    // mux off the bus path at the price of one extra cycle per access.
    assign idx     = i_avs_address[8:2];
    assign req     = i_avs_read | i_avs_write;
    assign done    = req & ack_reg;
    assign wr_done = done & i_avs_write & i_avs_byteenable[0];
    assign rd_done = done & i_avs_read;
    assign o_avs_waitrequest = req & ~ack_reg;
    assign o_avs_readdata    = rdata_reg;

    // Acknowledge toggles up for one cycle after each accepted request.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // Control view: lock, pin function and the sampled general pin level.
    always_comb begin
        ctrl_view = ttcr_pkg::RST_ZERO;
        ctrl_view[ttcr_pkg::CTRL_LOCK] = lock_reg;
        ctrl_view[ttcr_pkg::CTRL_FUNC_LSB +: 2] = func_reg;
        ctrl_view[ttcr_pkg::CTRL_GP_IN] = i_multi_pin;
    end

    // Read mux; unmapped indices read as zero.
    always_comb begin
        case (idx)
            ttcr_pkg::IDX_LIMIT:      rd_mux = limit_reg;
            ttcr_pkg::IDX_TACH:       rd_mux = tach_reg;
            ttcr_pkg::IDX_CFG:        rd_mux = cfg_reg & ttcr_pkg::CFG_WRITE_MASK;
            ttcr_pkg::IDX_IRQ_STATUS: rd_mux = irq_stat_reg;
            ttcr_pkg::IDX_IRQ_MASK:   rd_mux = irq_mask_reg;
            ttcr_pkg::IDX_TIMER:      rd_mux = dur_reg;
            ttcr_pkg::IDX_CTRL:       rd_mux = ctrl_view;
            default:                  rd_mux = ttcr_pkg::RST_ZERO;
        endcase
    end

    // Read data is loaded while waitrequest is high, so it stands at the
    // edge where the master takes it.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_reg <= 32'h00000000;
        end else if (i_avs_read && !ack_reg) begin
            rdata_reg <= {24'h000000, rd_mux};
        end
    end

    // ========================================================================
    // Writable registers.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            limit_reg <= ttcr_pkg::RST_LIMIT;
        end else if (wr_done && idx == ttcr_pkg::IDX_LIMIT) begin
            limit_reg <= i_avs_writedata[7:0];
        end
    end

    // Pulse count fields reset to code 01 each.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            tach_reg <= ttcr_pkg::RST_TACH;
        end else if (wr_done && idx == ttcr_pkg::IDX_TACH) begin
            tach_reg <= i_avs_writedata[7:0];
        end
    end

    // Configuration freezes once locked; bit 4 is never stored.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cfg_reg <= ttcr_pkg::RST_CFG;
        end else if (wr_done && idx == ttcr_pkg::IDX_CFG && !lock_reg) begin
            cfg_reg <= i_avs_writedata[7:0] & ttcr_pkg::CFG_WRITE_MASK;
        end
    end

    // Lock can only be set; only a reset clears it again.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            lock_reg <= 1'b0;
            func_reg <= 2'b00;
        end else if (wr_done && idx == ttcr_pkg::IDX_CTRL) begin
            lock_reg <= lock_reg | i_avs_writedata[ttcr_pkg::CTRL_LOCK];
            func_reg <= i_avs_writedata[ttcr_pkg::CTRL_FUNC_LSB +: 2];
        end
    end

    // Interrupt mask, same layout as the status register.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            irq_mask_reg <= ttcr_pkg::RST_ZERO;
        end else if (wr_done && idx == ttcr_pkg::IDX_IRQ_MASK) begin
            irq_mask_reg <= i_avs_writedata[7:0] & ttcr_pkg::IRQ_IMPL_MASK;
        end
    end

    // ========================================================================
    // Duration timer. The alarm is active low on the pin and counts only
    // while the pin serves the alarm function.
    assign alarm_on = (func_reg == ttcr_pkg::FUNC_ALARM) & ~i_multi_pin;
    assign start    = (state_reg == ttcr_pkg::TTCR_IDLE) & alarm_on;
    assign tick     = (tick_cnt_reg == TICK_LAST);

    // Step prescaler restarts with each assertion so the first step is full.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            tick_cnt_reg <= TICK_ZERO;
        end else if (start || tick) begin
            tick_cnt_reg <= TICK_ZERO;
        end else if (state_reg == ttcr_pkg::TTCR_TIMING) begin
            tick_cnt_reg <= tick_cnt_reg + TICK_ONE;
        end
    end

    // Timer state machine; saturation stops the count at its top value.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_reg <= ttcr_pkg::TTCR_IDLE;
        end else begin
            case (state_reg)
                ttcr_pkg::TTCR_IDLE: begin
                    if (alarm_on) begin
                        state_reg <= ttcr_pkg::TTCR_TIMING;
                    end
                end
                ttcr_pkg::TTCR_TIMING: begin
                    if (!alarm_on) begin
                        state_reg <= ttcr_pkg::TTCR_IDLE;
                    end else if (tick && dur_reg == (ttcr_pkg::DUR_MAX - ttcr_pkg::DUR_ONE)) begin
                        state_reg <= ttcr_pkg::TTCR_SATUR;
                    end
                end
                ttcr_pkg::TTCR_SATUR: begin
                    if (!alarm_on) begin
                        state_reg <= ttcr_pkg::TTCR_IDLE;
                    end
                end
                default: state_reg <= ttcr_pkg::TTCR_IDLE;
            endcase
        end
    end

    // Measured duration; it keeps the last value after release for software.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            dur_reg <= ttcr_pkg::DUR_ZERO;
        end else if (start) begin
            dur_reg <= ttcr_pkg::DUR_ZERO;
        end else if (state_reg == ttcr_pkg::TTCR_TIMING && alarm_on && tick) begin
            dur_reg <= dur_reg + ttcr_pkg::DUR_ONE;
        end
    end

    // Exceeded once the count passes the limit, or at once for a zero limit.
    assign exceed_evt =
        (start && limit_reg == ttcr_pkg::DUR_ZERO) ||
        (state_reg == ttcr_pkg::TTCR_TIMING && alarm_on && tick &&
         limit_reg != ttcr_pkg::DUR_ZERO && dur_reg == limit_reg);

    // ========================================================================
    // Sticky status: a read clears it, but an event in the same cycle wins.
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (rd_done && idx == ttcr_pkg::IDX_IRQ_STATUS) begin
            irq_stat_next = ttcr_pkg::RST_ZERO;
        end
        if (start) begin
            irq_stat_next[ttcr_pkg::IRQ_ASSERT] = 1'b1;
        end
        if (exceed_evt) begin
            irq_stat_next[ttcr_pkg::IRQ_EXCEED] = 1'b1;
        end
    end

    // Status flops and the level interrupt.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            irq_stat_reg <= ttcr_pkg::RST_ZERO;
            o_irq        <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            o_irq        <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // ========================================================================
    // Pin drive. A limit equal to the lowest code of the active format
    // switches that channel's drive off.
    assign remote_off = cfg_reg[ttcr_pkg::CFG_SIGNED] ?
        (i_remote_a_alarm_limit == ttcr_pkg::LIMIT_OFF_TWOS) :
        (i_remote_a_alarm_limit == ttcr_pkg::LIMIT_OFF_OFS64);
    assign local_off = cfg_reg[ttcr_pkg::CFG_SIGNED] ?
        (i_local_alarm_limit == ttcr_pkg::LIMIT_OFF_TWOS) :
        (i_local_alarm_limit == ttcr_pkg::LIMIT_OFF_OFS64);
    assign alarm_drive =
        (cfg_reg[ttcr_pkg::CFG_REMOTE_EN] & i_remote_a_over_limit & ~remote_off) |
        (cfg_reg[ttcr_pkg::CFG_LOCAL_EN] & i_local_over_limit & ~local_off);

    // The alarm pulls the pin low; the general output follows polarity.
    always_comb begin
        pin_next = 1'b1;
        oe_next  = 1'b0;
        case (func_reg)
            ttcr_pkg::FUNC_ALARM: begin
                pin_next = 1'b0;
                oe_next  = alarm_drive;
            end
            ttcr_pkg::FUNC_GPIO: begin
                pin_next = cfg_reg[ttcr_pkg::CFG_POL] ? i_gp_out_value : ~i_gp_out_value;
                oe_next  = cfg_reg[ttcr_pkg::CFG_DIR];
            end
            default: begin
                pin_next = 1'b1;
                oe_next  = 1'b0;
            end
        endcase
    end

    // Registered pin outputs and format selects.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_multi_pin            <= 1'b1;
            o_multi_pin_oe         <= 1'b0;
            o_signed_format_select <= 1'b0;
            o_offset_range_select  <= 1'b0;
        end else begin
            o_multi_pin            <= pin_next;
            o_multi_pin_oe         <= oe_next;
            o_signed_format_select <= cfg_reg[ttcr_pkg::CFG_SIGNED];
            o_offset_range_select  <= cfg_reg[ttcr_pkg::CFG_RANGE];
        end
    end

    // ========================================================================
    // Pulse counts per fan, code plus one, each from its own field.
    genvar g;
    generate
        for (g = 0; g < N_FANS; g = g + 1) begin : g_fan
            always_ff @(posedge i_clk) begin
                if (!i_nrst) begin
                    o_tach_pulses[g*3 +: 3] <=
                        {1'b0, ttcr_pkg::RST_TACH[g*ttcr_pkg::TACH_FW +: ttcr_pkg::TACH_FW]} + 3'h1;
                end else begin
                    o_tach_pulses[g*3 +: 3] <=
                        {1'b0, tach_reg[g*ttcr_pkg::TACH_FW +: ttcr_pkg::TACH_FW]} + 3'h1;
                end
            end
        end
    endgenerate

endmodule

// [verif/ttcr_host.sv]
// Host bus master model.
`timescale 1ns/1ns
module ttcr_host (
    input  wire logic        i_clk,
    input  wire logic        i_waitrequest,
    input  wire logic [31:0] i_readdata,
    output logic      [8:0]  o_address,
    output logic             o_read,
    output logic             o_write,
    output logic      [31:0] o_writedata,
    output logic      [3:0]  o_byteenable
);
    // ========================================================================
    // Idle from time zero, so nothing is requested in reset.
    initial begin
        {o_address, o_read, o_write, o_writedata, o_byteenable} = '0;
    end

    // One access, held until the edge at which waitrequest is sampled low.
    task automatic access(input logic wr, input logic [6:0] idx, input logic [7:0] d,
                          input logic [3:0] be, output logic [31:0] q);
        @(posedge i_clk);
        o_address <= {idx, 2'b00};
        o_read <= !wr;
        o_write <= wr;
        o_writedata <= {24'h000000, d};
        o_byteenable <= be;
        @(posedge i_clk);
        while (i_waitrequest !== 1'b0) @(posedge i_clk);
        q = i_readdata;
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask
endmodule

// [verif/ttcr_top_assertions.sv]
// Assertion checker for the configuration register block.
`timescale 1ns/1ns
module ttcr_checker #(
    parameter int N_FANS      = 4,
    parameter int STEP_CYCLES = 4
) (
    input wire logic                i_clk,
    input wire logic                i_nrst,
    input wire logic [8:0]          i_avs_address,
    input wire logic                i_avs_read,
    input wire logic                i_avs_write,
    input wire logic [31:0]         i_avs_writedata,
    input wire logic [3:0]          i_avs_byteenable,
    input wire logic [31:0]         o_avs_readdata,
    input wire logic                o_avs_waitrequest,
    input wire logic                o_multi_pin,
    input wire logic                o_multi_pin_oe,
    input wire logic                i_gp_out_value,
    input wire logic                i_remote_a_over_limit,
    input wire logic [7:0]          i_remote_a_alarm_limit,
    input wire logic                i_local_over_limit,
    input wire logic [7:0]          i_local_alarm_limit,
    input wire logic                o_signed_format_select,
    input wire logic                o_offset_range_select,
    input wire logic [N_FANS*3-1:0] o_tach_pulses,
    input wire logic                o_irq
);
    logic [6:0] idx;
    logic       wr_ok, lock_h, oe_q, pin_q, alarm_oe;
    logic [7:0] cfg_h, tach_h, off_code;
    logic [1:0] func_h;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // Pulse count is the code plus one.
    function automatic logic [N_FANS*3-1:0] tach_exp(input logic [7:0] f);
        for (int k = 0; k < N_FANS; k++) tach_exp[k*3 +: 3] = {1'b0, f[k*2 +: 2]} + 3'h1;
    endfunction

    // ========================================================================
    // Shadow of the configuration, pulse count and control fields.
    assign idx = i_avs_address[8:2];
    assign wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cfg_h <= ttcr_pkg::RST_CFG;
            tach_h <= ttcr_pkg::RST_TACH;
            func_h <= 2'h0;
            lock_h <= 1'b0;
        end else if (wr_ok) begin
            if (idx == ttcr_pkg::IDX_CFG && !lock_h) begin
                cfg_h <= i_avs_writedata[7:0] & ttcr_pkg::CFG_WRITE_MASK;
            end
            if (idx == ttcr_pkg::IDX_TACH) begin
                tach_h <= i_avs_writedata[7:0];
            end
            if (idx == ttcr_pkg::IDX_CTRL) begin
                func_h <= i_avs_writedata[2:1];
                lock_h <= lock_h | i_avs_writedata[0];
            end
        end
    end

    // Expected pin drive, registered like the block's pin.
    assign off_code = cfg_h[0] ? ttcr_pkg::LIMIT_OFF_TWOS : ttcr_pkg::LIMIT_OFF_OFS64;
    assign alarm_oe = (cfg_h[5] && i_remote_a_over_limit && i_remote_a_alarm_limit != off_code)
                   || (cfg_h[6] && i_local_over_limit && i_local_alarm_limit != off_code);
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            oe_q <= 1'b0;
            pin_q <= 1'b1;
        end else begin
            oe_q <= (func_h == ttcr_pkg::FUNC_GPIO) ? cfg_h[2]
                  : (func_h == ttcr_pkg::FUNC_ALARM) && alarm_oe;
            pin_q <= (func_h == ttcr_pkg::FUNC_GPIO) ? (i_gp_out_value ^ ~cfg_h[3]) : 1'b0;
        end
    end

    // ========================================================================
    sequence s_req_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_wr_done(logic [6:0] at);
        wr_ok && idx == at;
    endsequence

    AST_WAIT_ONE: assert property (s_req_wait |=> !o_avs_waitrequest)
        else $error("wait over one cycle");
    AST_WAIT_IDLE: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait with no request");
    AST_RDATA_UPPER: assert property (i_avs_read && !o_avs_waitrequest |->
        o_avs_readdata[31:8] == 24'h000000) else $error("upper read data set");
    AST_RESET_OUT: assert property ($rose(i_nrst) |-> !o_multi_pin_oe && !o_irq
        && o_tach_pulses == tach_exp(ttcr_pkg::RST_TACH)) else $error("bad reset outputs");
    AST_TACH_FIELDS: assert property (s_wr_done(ttcr_pkg::IDX_TACH) |-> ##2
        o_tach_pulses == tach_exp(tach_h)) else $error("pulse counts wrong");
    AST_SELECTS: assert property (s_wr_done(ttcr_pkg::IDX_CFG) |-> ##2
        o_signed_format_select == cfg_h[0] && o_offset_range_select == cfg_h[1])
        else $error("selects wrong");
    AST_PIN_OE: assert property (o_multi_pin_oe == oe_q)
        else $error("pin enable wrong");
    AST_PIN_LEVEL: assert property (o_multi_pin_oe |-> o_multi_pin == pin_q)
        else $error("pin level wrong");
    AST_CFG_BIT4: assert property (i_avs_read && !o_avs_waitrequest
        && idx == ttcr_pkg::IDX_CFG |-> !o_avs_readdata[4]) else $error("reserved bit set");
endmodule

bind ttcr_top ttcr_checker #(.N_FANS(N_FANS), .STEP_CYCLES(STEP_CYCLES)) chk_u (.*);

// [verif/ttcr_top_tb.sv]
// Self-checking bench for the configuration register block.
`timescale 1ns/1ns
module ttcr_top_tb;
    logic        clk, nrst, ext_low, gp_val, r_over, l_over, mpin;
    logic        rd, wr, waitreq, pin_out, oe, irq, sgn, rng;
    logic [7:0]  r_lim, l_lim;
    logic [8:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [3:0]  be;
    logic [11:0] tach;
    int          failures, comparisons;

    // Pulled-up pin; ext_low is an outside device pulling it low.
    assign mpin = oe ? pin_out : !ext_low;

    ttcr_top #(.N_FANS(4), .STEP_CYCLES(4)) dut_u (
        .i_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_multi_pin(mpin),
        .o_multi_pin(pin_out), .o_multi_pin_oe(oe), .i_gp_out_value(gp_val),
        .i_remote_a_over_limit(r_over), .i_remote_a_alarm_limit(r_lim),
        .i_local_over_limit(l_over), .i_local_alarm_limit(l_lim),
        .o_signed_format_select(sgn), .o_offset_range_select(rng),
        .o_tach_pulses(tach), .o_irq(irq));

    ttcr_host host_u (
        .i_clk(clk), .i_waitrequest(waitreq), .i_readdata(rdata), .o_address(addr),
        .o_read(rd), .o_write(wr), .o_writedata(wdata), .o_byteenable(be));

    // ========================================================================
    // Shared helpers.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [6:0] idx, input logic [7:0] d);
        host_u.access(1'b1, idx, d, 4'hF, q);
    endtask
    task automatic rchk(input logic [6:0] idx, input logic [7:0] exp);
        host_u.access(1'b0, idx, 8'h00, 4'hF, q);
        chk(q, exp);
    endtask
    task automatic settle;
        repeat (3) @(negedge clk);
    endtask
    // The level counts only while the block drives the pin.
    task automatic pchk(input logic e_oe, input logic e_pin);
        settle();
        chk(oe, e_oe);
        if (e_oe) chk(pin_out, e_pin);
    endtask

    // ========================================================================
    // Scenarios.
    task automatic t_reset;
        rchk(7'h7A, 8'h00);
        rchk(7'h7B, 8'h55);
        rchk(7'h7C, 8'h00);
        rchk(7'h10, 8'h00);
        chk(tach, 12'h492);
        w(7'h7A, 8'hFF);
        rchk(7'h7A, 8'hFF);
    endtask
    task automatic t_tach;
        host_u.access(1'b1, 7'h7B, 8'h00, 4'h0, q);
        rchk(7'h7B, 8'h55);
        w(7'h7B, 8'hE4);
        settle();
        chk(tach, 12'h8D1);
        rchk(7'h7B, 8'hE4);
    endtask
    task automatic t_cfg;
        w(7'h7C, 8'hFF);
        rchk(7'h7C, 8'hEF);
        settle();
        chk({sgn, rng}, 2'b11);
        w(7'h7C, 8'h02);
        settle();
        chk({sgn, rng}, 2'b01);
    endtask
    task automatic t_gpio;
        w(7'h70, 8'h06);
        @(posedge clk) gp_val <= 1'b1;
        w(7'h7C, 8'h0C);
        pchk(1'b1, 1'b1);
        w(7'h7C, 8'h04);
        pchk(1'b1, 1'b0);
        w(7'h7C, 8'h00);
        pchk(1'b0, 1'b0);
        w(7'h70, 8'h00);
        w(7'h7C, 8'h0C);
        pchk(1'b0, 1'b0);
    endtask
    task automatic t_alarm;
        w(7'h70, 8'h02);
        @(posedge clk) r_over <= 1'b1;
        r_lim <= 8'h10;
        w(7'h7C, 8'h20);
        pchk(1'b1, 1'b0);
        @(posedge clk) r_lim <= 8'h00;
        pchk(1'b0, 1'b0);
        w(7'h7C, 8'h21);
        pchk(1'b1, 1'b0);
        @(posedge clk) r_lim <= 8'h80;
        pchk(1'b0, 1'b0);
        @(posedge clk) l_over <= 1'b1;
        l_lim <= 8'h10;
        w(7'h7C, 8'h40);
        pchk(1'b1, 1'b0);
        w(7'h7C, 8'h00);
        pchk(1'b0, 1'b0);
    endtask
    // A 4-cycle step and a limit of 2 trip 12 edges after the start edge.
    task automatic t_timer;
        w(7'h71, 8'h20);
        w(7'h7A, 8'h00);
        host_u.access(1'b0, 7'h42, 8'h00, 4'hF, q);
        settle();
        chk(irq, 1'b0);
        @(posedge clk) ext_low <= 1'b1;
        settle();
        chk(irq, 1'b1);
        @(posedge clk) ext_low <= 1'b0;
        rchk(7'h42, 8'h21);
        settle();
        chk(irq, 1'b0);
        rchk(7'h42, 8'h00);
        w(7'h7A, 8'h02);
        @(posedge clk) ext_low <= 1'b1;
        repeat (10) @(negedge clk);
        chk(irq, 1'b0);
        repeat (5) @(negedge clk);
        chk(irq, 1'b1);
        @(posedge clk) ext_low <= 1'b0;
        rchk(7'h72, 8'h03);
        rchk(7'h42, 8'h21);
    endtask
    task automatic t_lock;
        w(7'h7C, 8'h03);
        w(7'h70, 8'h03);
        w(7'h7C, 8'h40);
        rchk(7'h7C, 8'h03);
        settle();
        chk({sgn, rng}, 2'b11);
    endtask

    // ========================================================================
    // Verdict, reached from the main sequence or the watchdog.
    task automatic give_verdict;
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        nrst = 1'b0;
        {ext_low, gp_val, r_over, l_over, r_lim, l_lim} = '0;
        failures = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_tach();
        t_cfg();
        t_gpio();
        t_alarm();
        @(posedge clk) l_over <= 1'b0;
        t_timer();
        t_lock();
        give_verdict();
    end

    // Cuts a hang short; the run needs under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule
